/* File: hw/sirq_pkg.sv */
// constants and types shared by the serial interrupt slave agent
package sirq_pkg;

   // ****************************************
   // synchroniser and frame timing
   // ****************************************
   localparam int SYNC_STAGES = 2;
   localparam int HOST_FRAMES_DEF = 17;
   localparam logic [5:0] FIRST_FRAME = 6'h01;
   localparam logic [5:0] FIRST_IRQ_SLOT = 6'h02;
   localparam logic [5:0] LAST_IRQ_SLOT = 6'h10;
   localparam logic [5:0] MGMT_SLOT = 6'h03;
   localparam logic [5:0] SLOT_RESET = 6'h00;

   // ****************************************
   // stop frame widths in clocks
   // ****************************************
   localparam logic [2:0] STOP_QUIET_CLKS = 3'h2;
   localparam logic [2:0] STOP_CONT_CLKS = 3'h3;
   localparam logic [2:0] STOP_CNT_MAX = 3'h7;
   localparam logic [2:0] STOP_CNT_FIRST = 3'h1;
   localparam int STOP_TO_START_CLKS = 2;

   // ****************************************
   // management interrupt enable register 2
   // ****************************************
   localparam int MGMT_SER_BIT = 6;
   localparam int MGMT_PIN_BIT = 7;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic QUIET_RESET = 1'b0;
   localparam logic [15:0] LEVEL_RESET = 16'hffff;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {PH_SAMPLE, PH_RECOV, PH_TURN} sirq_phase_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_OWN_START, ST_OWN_WAIT, ST_START_LOW, ST_FRAMES, ST_STOP_WAIT, ST_STOP_LOW
   } sirq_state_t;

   typedef struct packed {
      logic oe;
      logic out;
   } sirq_drive_t;

endpackage

/* File: hw/sirq_sync.sv */
// two-flop synchroniser for the serial interrupt line
`timescale 1ns/10ps
`default_nettype none
module sirq_sync import sirq_pkg::*; #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   // line idles high, so both stages reset high
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         stage1 <= '1;
         sync_out <= '1;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule
`default_nettype wire

/* File: hw/sirq_pend.sv */
// per-line change tracking for the interrupt levels
`timescale 1ns/10ps
`default_nettype none
module sirq_pend import sirq_pkg::*; #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // levels and slot clears
   input wire logic [WIDTH-1:0] level,
   input wire logic [WIDTH-1:0] clear,
   output logic [WIDTH-1:0] pend
);

   logic [WIDTH-1:0] prev;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge sys_clk) begin
            if (!reset_n) begin
               prev[i] <= LEVEL_RESET[i];
            end else begin
               prev[i] <= level[i];
            end
         end

         // a change in the clearing cycle still counts
         always_ff @(posedge sys_clk) begin
            if (!reset_n) begin
               pend[i] <= 1'b0;
            end else if (level[i] != prev[i]) begin
               pend[i] <= 1'b1;
            end else if (clear[i]) begin
               pend[i] <= 1'b0;
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

/* File: hw/sirq_agent.sv */
// serial interrupt slave agent: start, data and stop frame handling
//
// Overview of operation
// - in quiet idle, drive line low one clock, then release, never high
// - never start a start frame while a cycle is active
// - in quiet mode a level change requests a start frame unless carried
// - in continuous mode never start a frame; only the host does
// - mode changes only at a stop frame
// - continuous mode after reset; wait for host start frame
// - stop low two clocks selects quiet, three selects continuous
// - own start no earlier than second clock after stop rising edge
// - frames counted from start rising edge, three clocks each
// - sample phase drives low only when the reported level is low
// - recovery drives high one clock only after driving low
// - turn-around phase always releases the line
// - report low levels whichever agent started the cycle
// - frame n sample at 3n-1 clocks; periods 2 to 16 carry lines 1-15
// - period 3 carries line 2 or the management interrupt
// - management enable bit 6 gates serial frame, bit 7 the pin
// - line 13 is carried in period 14 like any other line
// - line released during reset; come out in continuous idle
// - drive and sample on the rising edge of the bus clock
`timescale 1ns/10ps
`default_nettype none
module sirq_agent import sirq_pkg::*; #(
   parameter int HOST_FRAMES = HOST_FRAMES_DEF
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // serial interrupt line
   input wire logic sio_in,
   output sirq_drive_t line_drv,
   // interrupt sources, bit n is line n, active low
   input wire logic [15:0] irq_level_n,
   input wire logic mgmt_interrupt_request,
   input wire logic [7:0] mgmt_enable2,
   // status
   output logic mgmt_pin_n,
   output logic quiet_mode,
   output logic cycle_active
);

   // ****************************************
   // line input and reported levels
   // ****************************************
   logic line_s;
   logic [15:0] rep_n;
   logic [15:0] pend;
   logic [15:0] pend_clr;

   sirq_sync #(.WIDTH(1)) u_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .async_in(sio_in),
      .sync_out(line_s)
   );

   always_comb begin
      rep_n = irq_level_n;
      rep_n[0] = 1'b1;
      // shared slot: line 2 or the management interrupt
      rep_n[2] = irq_level_n[2] & ~(mgmt_interrupt_request & mgmt_enable2[MGMT_SER_BIT]);
   end

   sirq_pend #(.WIDTH(16)) u_pend (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .level(rep_n),
      .clear(pend_clr),
      .pend(pend)
   );

   // ****************************************
   // state and frame position
   // ****************************************
   sirq_state_t st;
   sirq_phase_t phase;
   sirq_phase_t next_phase;
   logic [5:0] slot;
   logic [5:0] next_slot;
   logic [5:0] irq_idx;
   logic [2:0] stop_cnt;
   logic drove_low;
   logic own_start;
   logic start_req;
   logic idle_start;
   logic last_frame;
   logic in_irq_slot;

   assign start_req = quiet_mode && (|pend);
   // sync latency already places this past the second clock after stop
   assign idle_start = (st == ST_IDLE) && line_s && start_req;
   assign last_frame = (slot == 6'(HOST_FRAMES)) && (phase == PH_TURN);

   always_comb begin
      next_slot = slot;
      next_phase = phase;
      unique case (phase)
         PH_SAMPLE: next_phase = PH_RECOV;
         PH_RECOV: next_phase = PH_TURN;
         PH_TURN: begin
            next_phase = PH_SAMPLE;
            next_slot = slot + 6'h01;
         end
      endcase
   end

   assign irq_idx = next_slot - FIRST_FRAME;
   assign in_irq_slot = (next_slot >= FIRST_IRQ_SLOT) && (next_slot <= LAST_IRQ_SLOT);

   always_comb begin
      pend_clr = 16'h0000;
      if (st == ST_FRAMES && next_phase == PH_SAMPLE && in_irq_slot) begin
         pend_clr[irq_idx[3:0]] = 1'b1;
      end
   end

   // ****************************************
   // cycle sequencing
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         st <= ST_IDLE;
      end else begin
         unique case (st)
            ST_IDLE: begin
               if (!line_s) begin
                  st <= ST_START_LOW;
               end else if (idle_start) begin
                  st <= ST_OWN_START;
               end
            end
            ST_OWN_START: st <= ST_OWN_WAIT;
            ST_OWN_WAIT: begin
               if (!line_s) begin
                  st <= ST_START_LOW;
               end
            end
            ST_START_LOW: begin
               if (line_s) begin
                  st <= ST_FRAMES;
               end
            end
            ST_FRAMES: begin
               if (last_frame) begin
                  st <= ST_STOP_WAIT;
               end
            end
            ST_STOP_WAIT: begin
               if (!line_s) begin
                  st <= ST_STOP_LOW;
               end
            end
            ST_STOP_LOW: begin
               if (line_s) begin
                  st <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // rising edge seen at clock 2; registers describe the next clock
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         slot <= SLOT_RESET;
         phase <= PH_SAMPLE;
      end else if (st == ST_START_LOW && line_s) begin
         slot <= FIRST_FRAME;
         phase <= PH_RECOV;
      end else if (st == ST_FRAMES) begin
         slot <= next_slot;
         phase <= next_phase;
      end
   end

   // ****************************************
   // stop width and mode
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         stop_cnt <= 3'h0;
      end else if (st == ST_STOP_WAIT && !line_s) begin
         stop_cnt <= STOP_CNT_FIRST;
      end else if (st == ST_STOP_LOW && !line_s && stop_cnt != STOP_CNT_MAX) begin
         stop_cnt <= stop_cnt + 3'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         quiet_mode <= QUIET_RESET;
      end else if (st == ST_STOP_LOW && line_s) begin
         if (stop_cnt == STOP_QUIET_CLKS) begin
            quiet_mode <= 1'b1;
         end else if (stop_cnt >= STOP_CONT_CLKS) begin
            quiet_mode <= 1'b0;
         end
      end
   end

   // ****************************************
   // line drive
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         line_drv <= '0;
         drove_low <= 1'b0;
         own_start <= 1'b0;
      end else begin
         line_drv <= '0;
         own_start <= 1'b0;
         if (idle_start) begin
            line_drv <= '{oe: 1'b1, out: 1'b0};
            own_start <= 1'b1;
         end else if (st == ST_FRAMES) begin
            if (next_phase == PH_SAMPLE) begin
               drove_low <= in_irq_slot && !rep_n[irq_idx[3:0]];
               if (in_irq_slot && !rep_n[irq_idx[3:0]]) begin
                  line_drv <= '{oe: 1'b1, out: 1'b0};
               end
            end else if (next_phase == PH_RECOV && drove_low) begin
               line_drv <= '{oe: 1'b1, out: 1'b1};
               drove_low <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         mgmt_pin_n <= 1'b1;
         cycle_active <= 1'b0;
      end else begin
         mgmt_pin_n <= ~(mgmt_interrupt_request & mgmt_enable2[MGMT_PIN_BIT]);
         cycle_active <= (st == ST_START_LOW) || (st == ST_FRAMES) ||
            (st == ST_STOP_WAIT) || (st == ST_STOP_LOW);
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   a_reset_release: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(reset_n) |-> !line_drv.oe)
      else $error("line driven right after reset");

   a_reset_mode_cont: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(reset_n) |-> !quiet_mode)
      else $error("not continuous after reset");

   a_start_one_clk: assert property (@(posedge sys_clk) disable iff (!reset_n)
      own_start |-> line_drv.oe && !line_drv.out ##1 !line_drv.oe)
      else $error("own start not a single low clock");

   a_start_from_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
      own_start |-> $past(st) == ST_IDLE && st == ST_OWN_START)
      else $error("start frame issued outside idle");

   a_cont_passive: assert property (@(posedge sys_clk) disable iff (!reset_n)
      own_start |-> $past(quiet_mode))
      else $error("start frame in continuous mode");

   a_recov_then_turn: assert property (@(posedge sys_clk) disable iff (!reset_n)
      line_drv.oe && !line_drv.out && !own_start |=>
         line_drv.oe && line_drv.out ##1 !line_drv.oe)
      else $error("sample low not followed by recovery high and release");

   a_sample_slot: assert property (@(posedge sys_clk) disable iff (!reset_n)
      line_drv.oe && !line_drv.out && !own_start |->
         phase == PH_SAMPLE && slot >= FIRST_IRQ_SLOT && slot <= LAST_IRQ_SLOT)
      else $error("low driven outside an interrupt sample clock");

   a_mode_at_stop: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $changed(quiet_mode) |-> $past(st) == ST_STOP_LOW &&
         $past(stop_cnt) >= STOP_QUIET_CLKS)
      else $error("mode changed outside a stop frame");

   a_high_only_recov: assert property (@(posedge sys_clk) disable iff (!reset_n)
      line_drv.oe && line_drv.out |-> $past(line_drv.oe) && !$past(line_drv.out))
      else $error("line driven high without preceding low");

   a_turn_release: assert property (@(posedge sys_clk) disable iff (!reset_n)
      st == ST_FRAMES && phase == PH_TURN |-> !line_drv.oe)
      else $error("line driven in a turn-around clock");

   a_start_not_active: assert property (@(posedge sys_clk) disable iff (!reset_n)
      own_start |-> !cycle_active)
      else $error("own start while a cycle is active");

   a_frame_origin: assert property (@(posedge sys_clk) disable iff (!reset_n)
      st == ST_FRAMES && $past(st) == ST_START_LOW |-> slot == FIRST_FRAME && phase == PH_RECOV)
      else $error("frame count not started at start rising edge");

   a_quiet_stop_width: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(quiet_mode) |-> $past(stop_cnt) == STOP_QUIET_CLKS)
      else $error("quiet mode without a two clock stop");

   a_cont_stop_width: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $fell(quiet_mode) |-> $past(stop_cnt) >= STOP_CONT_CLKS)
      else $error("continuous mode without a three clock stop");

endmodule
`default_nettype wire

/* File: dv/sirq_host_model.sv */
// host controller model for the serial interrupt line
`timescale 1ns/10ps
`default_nettype none
module sirq_host_model import sirq_pkg::*; #(
   parameter int FRAMES = HOST_FRAMES_DEF
) (
   // clock
   input wire logic sys_clk,
   // resolved line and host drive
   input wire logic sirq_line,
   output var logic host_oe,
   output var logic host_out
);
   // clock index within the cycle, -1 outside the data frames
   int clk_no = -1;
   int cyc = 0;
   int stop_cyc = -100;

   initial begin
      host_oe = 1'b0;
      host_out = 1'b0;
   end

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
   end

   // ****************************************
   // one full cycle, drives just after rising edges
   // ****************************************
   task automatic run_cycle(input bit own, input int low_len, input int stop_len,
                            output logic [31:0] got, output bit started);
      int n;
      got = 32'hffff_ffff;
      started = 1'b1;
      n = 0;
      if (own) begin
         do begin
            @(posedge sys_clk);
            n++;
         end while (sirq_line !== 1'b0 && n < 100);
         started = (n < 100);
         // agent gave the first low clock
         low_len = low_len - 1;
      end
      if (started) begin
         for (int i = 0; i < low_len; i++) begin
            if (i > 0 || !own) @(posedge sys_clk);
            host_oe <= 1'b1;
            host_out <= 1'b0;
         end
         @(posedge sys_clk);
         host_out <= 1'b1;
         clk_no <= 0;
         for (int k = 1; k <= 3 * FRAMES + 1; k++) begin
            @(posedge sys_clk);
            host_oe <= 1'b0;
            clk_no <= k;
            if (k % 3 == 0) got[k / 3] = sirq_line;
         end
         for (int i = 0; i < stop_len; i++) begin
            @(posedge sys_clk);
            host_oe <= 1'b1;
            host_out <= 1'b0;
            clk_no <= -1;
         end
         @(posedge sys_clk);
         host_out <= 1'b1;
         stop_cyc = cyc;
         @(posedge sys_clk);
         host_oe <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

/* File: dv/sirq_agent_tb_top.sv */
// self-checking bench for the serial interrupt slave agent
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) begin \
         n_errors++; \
         $display("wrong value %s expected %h seen %h", what, exp, got); \
      end \
   end
module sirq_agent_tb_top import sirq_pkg::*; ;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [15:0] irq_level_n = 16'hffff;
   logic mgmt_interrupt_request = 1'b0;
   logic [7:0] mgmt_enable2 = 8'h00;
   sirq_drive_t line_drv;
   logic mgmt_pin_n;
   logic quiet_mode;
   logic cycle_active;
   logic host_oe;
   logic host_out;
   wire logic sirq_line;
   logic [31:0] seed = 32'h0c6e;
   logic [31:0] exp_now = 32'hffff_ffff;
   bit last_low = 1'b0;
   int last_stop = 3;
   int own_starts = 0;
   int n_errors = 0;
   int n_compared = 0;

   // low wins, then driven high, else pulled up
   assign sirq_line = ((host_oe && !host_out) || (line_drv.oe && !line_drv.out)) ? 1'b0 : 1'b1;

   always #5 sys_clk = ~sys_clk;

   sirq_agent #(.HOST_FRAMES(17)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
      .sio_in(sirq_line), .line_drv(line_drv), .irq_level_n(irq_level_n),
      .mgmt_interrupt_request(mgmt_interrupt_request), .mgmt_enable2(mgmt_enable2),
      .mgmt_pin_n(mgmt_pin_n), .quiet_mode(quiet_mode), .cycle_active(cycle_active));

   sirq_host_model #(.FRAMES(17)) host (.sys_clk(sys_clk), .sirq_line(sirq_line),
      .host_oe(host_oe), .host_out(host_out));

   // ****************************************
   // model and helpers
   // ****************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [31:0] model(input logic [15:0] lv, input logic req,
                                         input logic [7:0] en);
      model = 32'hffff_ffff;
      for (int n = 2; n <= 16; n++) model[n] = lv[n - 1];
      if (req && en[MGMT_SER_BIT]) model[3] = 1'b0;
   endfunction

   task automatic do_cycle(input bit own, input int low_len, input int stop_len);
      logic [31:0] got;
      bit started;
      exp_now = model(irq_level_n, mgmt_interrupt_request, mgmt_enable2);
      host.run_cycle(own, low_len, stop_len, got, started);
      last_stop = stop_len;
      `CHK("start taken", 1'b1, started)
      `CHK("slot levels", exp_now[17:1], got[17:1])
   endtask

   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ****************************************
   // line monitor
   // ****************************************
   always @(negedge sys_clk) begin
      if (reset_n && host.cyc - host.stop_cyc == 6) begin
         `CHK("mode after stop", last_stop == 2, quiet_mode)
      end
      if (reset_n && line_drv.oe) begin
         if (host.clk_no < 0) begin
            own_starts++;
            `CHK("own start level", 1'b0, line_drv.out)
            `CHK("own start gap", 1'b1, host.cyc - host.stop_cyc >= 3)
            `CHK("own start mode", 1'b1, quiet_mode)
            `CHK("idle before own start", 1'b0, cycle_active)
         end else if (host.clk_no % 3 == 2) begin
            `CHK("sample level", 1'b0, line_drv.out)
            `CHK("sample slot", 1'b0, exp_now[(host.clk_no + 1) / 3])
         end else begin
            `CHK("turn-around release", 1'b1, host.clk_no % 3 == 0)
            `CHK("recovery level", 1'b1, line_drv.out)
            `CHK("recovery after low", 1'b1, last_low)
         end
      end
      if (reset_n && host.clk_no >= 0) begin
         `CHK("cycle active", 1'b1, cycle_active)
      end
      last_low = line_drv.oe && !line_drv.out && host.clk_no % 3 == 2;
   end

   initial begin
      repeat (5000) @(posedge sys_clk);
      n_errors++;
      close_out();
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (5) @(negedge sys_clk);
      `CHK("drive in reset", 1'b0, line_drv.oe)
      `CHK("mode in reset", 1'b0, quiet_mode)
      repeat (5) @(negedge sys_clk);
      reset_n = 1'b1;
      irq_level_n = 16'h5a5a;
      repeat (20) @(negedge sys_clk);
      `CHK("starts in continuous", 0, own_starts)
      `CHK("idle after reset", 1'b0, cycle_active)
      $display("reset and continuous idle done");
      for (int i = 0; i < 8; i++) begin
         @(negedge sys_clk);
         seed = lfsr(seed);
         irq_level_n = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : seed[15:0];
         mgmt_interrupt_request = i[0];
         mgmt_enable2 = {i[2:1], seed[21:16]};
         repeat (2) @(negedge sys_clk);
         `CHK("mgmt pin", !(i[0] && i[2]), mgmt_pin_n)
         do_cycle(1'b0, 4 + i % 5, (i == 7) ? 2 : 3);
      end
      $display("host cycles done");
      own_starts = 0;
      repeat (20) @(negedge sys_clk);
      `CHK("starts without change", 0, own_starts)
      irq_level_n[13] = ~irq_level_n[13];
      do_cycle(1'b1, 6, 2);
      `CHK("one own start", 1, own_starts)
      $display("own start done");
      own_starts = 0;
      fork
         do_cycle(1'b0, 4, 2);
         begin
            repeat (20) @(negedge sys_clk);
            irq_level_n[1] = ~irq_level_n[1];
         end
      join
      do_cycle(1'b1, 5, 3);
      `CHK("start after busy cycle", 1, own_starts)
      $display("change during cycle done");
      repeat (10) @(negedge sys_clk);
      close_out();
   end
endmodule
`default_nettype wire
